// File: src/ssc_spindle_scaler.sv
`timescale 1ns/1ps
// Operation
// - Coded override inputs count only while the method select input is low.
// - The coded override picks a ratio from 50 to 120 percent in 10 percent steps.
// - The override cannot change while halt, tapping or thread cutting is active.
// - Code bit4/bit2/bit1 maps 111=50,011=60,010=70,110=80,100=90,000=100,001=110,101=120 percent.
// - With method select high the override comes from the override register.
// - Each gear has a full-scale speed setting chosen by the gear inputs.
// - Output is S command over gear limit times override over 100 times full scale.
// - The S command is clamped to the selected gear's maximum speed before scaling.
// - While halt is asserted with ce high the speed output is zero; with ce low it holds its last value.
// - With the serial link selected the speed goes out serially instead of as a level.
// - On halt release the output returns to the value computed from the command.
// - While halt is asserted the coded override inputs are ignored.
module ssc_spindle_scaler (
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic [ssc_pkg::ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [ssc_pkg::DATA_W-1:0] avs_writedata,
    output logic [ssc_pkg::DATA_W-1:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic override_method_select,
    input wire logic override_code_bit1,
    input wire logic override_code_bit2,
    input wire logic override_code_bit4,
    input wire logic gear_select_low,
    input wire logic gear_select_high,
    input wire logic spindle_halt,
    input wire logic tapping_mode,
    input wire logic thread_cutting_mode,
    output logic [ssc_pkg::OUT_W-1:0] speed_level,
    output logic speed_serial_data,
    output logic speed_serial_frame
);

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchroniser
    ssc_pkg::ssc_pins_s pins_raw;
    ssc_pkg::ssc_pins_s pins_meta_q;
    ssc_pkg::ssc_pins_s pins_q;

    assign pins_raw.halt = spindle_halt;
    assign pins_raw.method = override_method_select;
    assign pins_raw.gear = {gear_select_high, gear_select_low};
    assign pins_raw.code = {override_code_bit4, override_code_bit2, override_code_bit1};
    assign pins_raw.tapping = tapping_mode;
    assign pins_raw.threading = thread_cutting_mode;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pins_meta_q <= '0;
            pins_q <= '0;
        end else if (ce) begin
            pins_meta_q <= pins_raw;
            pins_q <= pins_meta_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registers
    logic ctrl_serial_q;
    logic [ssc_pkg::S_W-1:0] scmd_q;
    logic [ssc_pkg::PCT_W-1:0] ovr_reg_q;
    logic [ssc_pkg::S_W-1:0] full_scale_q [ssc_pkg::GEARS];
    logic [ssc_pkg::S_W-1:0] max_speed_q [ssc_pkg::GEARS];
    logic [ssc_pkg::PCT_W-1:0] eff_ovr_q;
    logic [ssc_pkg::OUT_W-1:0] result_q;
    logic [ssc_pkg::OUT_W-1:0] speed_q;
    logic waitreq_q;
    logic [ssc_pkg::DATA_W-1:0] rdata_q;

    ////////////////////////////////////////////////////////////////////////////
    // Bus slave
    wire req = avs_read | avs_write;
    wire accept = req & ~waitreq_q;
    wire wr_en = accept & avs_write;
    wire sel_ctrl = (avs_address == ssc_pkg::OFS_CTRL);
    wire sel_scmd = (avs_address == ssc_pkg::OFS_SCMD);
    wire sel_ovr = (avs_address == ssc_pkg::OFS_OVR_REG);
    wire sel_status = (avs_address == ssc_pkg::OFS_STATUS);
    wire sel_speed = (avs_address == ssc_pkg::OFS_SPEED);
    wire sel_eff = (avs_address == ssc_pkg::OFS_EFF_OVR);
    wire sel_fs = (avs_address[5:4] == ssc_pkg::OFS_FULL_SCALE0[5:4]) & (avs_address[1:0] == 2'h0);
    wire sel_max = (avs_address[5:4] == ssc_pkg::OFS_MAX_SPEED0[5:4]) & (avs_address[1:0] == 2'h0);
    wire [1:0] gear_idx = avs_address[3:2];

    logic busy;
    logic ser_busy;
    logic blocked;
    logic [ssc_pkg::DATA_W-1:0] status_word;
    logic [ssc_pkg::DATA_W-1:0] rd_mux;

    always_comb begin
        status_word = '0;
        status_word[ssc_pkg::ST_HALT_BIT] = pins_q.halt;
        status_word[ssc_pkg::ST_METHOD_BIT] = pins_q.method;
        status_word[ssc_pkg::ST_GEAR_LSB +: 2] = pins_q.gear;
        status_word[ssc_pkg::ST_BLOCKED_BIT] = blocked;
        status_word[ssc_pkg::ST_BUSY_BIT] = busy;
        status_word[ssc_pkg::ST_SER_BUSY_BIT] = ser_busy;
    end

    // Read mux, unmapped offsets read zero
    always_comb begin
        if (sel_ctrl) begin
            rd_mux = {31'h0, ctrl_serial_q};
        end else if (sel_scmd) begin
            rd_mux = {16'h0, scmd_q};
        end else if (sel_ovr) begin
            rd_mux = {24'h0, ovr_reg_q};
        end else if (sel_status) begin
            rd_mux = status_word;
        end else if (sel_speed) begin
            rd_mux = {16'h0, speed_q};
        end else if (sel_eff) begin
            rd_mux = {24'h0, eff_ovr_q};
        end else if (sel_fs) begin
            rd_mux = {16'h0, full_scale_q[gear_idx]};
        end else if (sel_max) begin
            rd_mux = {16'h0, max_speed_q[gear_idx]};
        end else begin
            rd_mux = 32'h0;
        end
    end

    // One wait cycle, then the answer stands for the accepting edge
    wire wait_take = req & waitreq_q;
    wire rd_take = avs_read & waitreq_q;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            waitreq_q <= 1'b1;
        end else if (ce) begin
            waitreq_q <= ~wait_take;
        end
    end

    // Read data captured only for reads
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rdata_q <= '0;
        end else if (ce && rd_take) begin
            rdata_q <= rd_mux;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ctrl_serial_q <= 1'b0;
            scmd_q <= ssc_pkg::RST_SCMD;
            ovr_reg_q <= ssc_pkg::RST_OVR_REG;
        end else if (ce && wr_en) begin
            if (sel_ctrl) begin
                ctrl_serial_q <= avs_writedata[ssc_pkg::CTRL_SERIAL_BIT];
            end
            if (sel_scmd) begin
                scmd_q <= avs_writedata[ssc_pkg::S_W-1:0];
            end
            if (sel_ovr) begin
                ovr_reg_q <= avs_writedata[ssc_pkg::PCT_W-1:0];
            end
        end
    end

    // Per-gear limit and clamp settings
    for (genvar g = 0; g < ssc_pkg::GEARS; g++) begin : g_gear
        wire fs_hit = wr_en & sel_fs & (gear_idx == 2'(g));
        wire max_hit = wr_en & sel_max & (gear_idx == 2'(g));
        always_ff @(posedge clk or negedge rstn) begin
            if (!rstn) begin
                full_scale_q[g] <= ssc_pkg::RST_FULL_SCALE;
                max_speed_q[g] <= ssc_pkg::RST_MAX_SPEED;
            end else if (ce) begin
                if (fs_hit) begin
                    full_scale_q[g] <= avs_writedata[ssc_pkg::S_W-1:0];
                end
                if (max_hit) begin
                    max_speed_q[g] <= avs_writedata[ssc_pkg::S_W-1:0];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Override selection
    function automatic logic [ssc_pkg::PCT_W-1:0] decode_pct(input logic [2:0] code);
        case (code)
            3'h7: decode_pct = ssc_pkg::PCT_50;
            3'h3: decode_pct = ssc_pkg::PCT_60;
            3'h2: decode_pct = ssc_pkg::PCT_70;
            3'h6: decode_pct = ssc_pkg::PCT_80;
            3'h4: decode_pct = ssc_pkg::PCT_90;
            3'h0: decode_pct = ssc_pkg::PCT_100;
            3'h1: decode_pct = ssc_pkg::PCT_110;
            default: decode_pct = ssc_pkg::PCT_120;
        endcase
    endfunction : decode_pct

    wire [ssc_pkg::PCT_W-1:0] code_pct = decode_pct(pins_q.code);
    wire [ssc_pkg::PCT_W-1:0] new_ovr = pins_q.method ? ovr_reg_q : code_pct;
    assign blocked = pins_q.halt | pins_q.tapping | pins_q.threading;

    // Override frozen while blocked, so halt also masks the code inputs
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            eff_ovr_q <= ssc_pkg::PCT_100;
        end else if (ce && !blocked) begin
            eff_ovr_q <= new_ovr;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Scaling divider
    wire [ssc_pkg::S_W-1:0] sel_max_speed = max_speed_q[pins_q.gear];
    wire [ssc_pkg::S_W-1:0] sel_limit = full_scale_q[pins_q.gear];
    wire [ssc_pkg::S_W-1:0] s_clamped = (scmd_q > sel_max_speed) ? sel_max_speed : scmd_q;
    wire [23:0] s_times_ovr = s_clamped * eff_ovr_q;
    wire [ssc_pkg::NUM_W-1:0] numer = s_times_ovr * ssc_pkg::FULL_SCALE_OUT;
    wire [ssc_pkg::DEN_W-1:0] denom = sel_limit * ssc_pkg::PCT_DIVISOR;

    ssc_pkg::ssc_state_e state_q;
    logic [ssc_pkg::DEN_W:0] rem_q;
    logic [ssc_pkg::NUM_W-1:0] quo_q;
    logic [ssc_pkg::DEN_W-1:0] den_q;
    logic [ssc_pkg::CNT_W-1:0] step_q;

    wire [ssc_pkg::DEN_W:0] trial = {rem_q[ssc_pkg::DEN_W-1:0], quo_q[ssc_pkg::NUM_W-1]};
    wire fits = (trial >= {1'b0, den_q});
    wire [ssc_pkg::DEN_W:0] trial_left = trial - {1'b0, den_q};
    wire over_scale = (quo_q > {24'h0, ssc_pkg::FULL_SCALE_OUT});
    wire [ssc_pkg::OUT_W-1:0] scaled = over_scale ? ssc_pkg::FULL_SCALE_OUT : quo_q[ssc_pkg::OUT_W-1:0];
    assign busy = (state_q != ssc_pkg::ST_IDLE);

    // Recomputes continuously from the live command, gear and override
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_q <= ssc_pkg::ST_IDLE;
            rem_q <= '0;
            quo_q <= '0;
            den_q <= '0;
            step_q <= '0;
            result_q <= '0;
        end else if (ce) begin
            case (state_q)
                ssc_pkg::ST_IDLE: begin
                    state_q <= ssc_pkg::ST_LOAD;
                end
                ssc_pkg::ST_LOAD: begin
                    rem_q <= '0;
                    quo_q <= numer;
                    den_q <= denom;
                    step_q <= '0;
                    state_q <= (denom == '0) ? ssc_pkg::ST_DONE : ssc_pkg::ST_DIV;
                end
                ssc_pkg::ST_DIV: begin
                    rem_q <= fits ? trial_left : trial;
                    quo_q <= {quo_q[ssc_pkg::NUM_W-2:0], fits};
                    step_q <= step_q + 6'h1;
                    if (step_q == ssc_pkg::DIV_STEPS - 6'h1) begin
                        state_q <= ssc_pkg::ST_DONE;
                    end
                end
                ssc_pkg::ST_DONE: begin
                    result_q <= (den_q == '0) ? '0 : scaled;
                    state_q <= ssc_pkg::ST_IDLE;
                end
                default: begin
                    state_q <= ssc_pkg::ST_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Output stage
    wire [ssc_pkg::OUT_W-1:0] speed_d = pins_q.halt ? '0 : result_q;
    wire [ssc_pkg::OUT_W-1:0] level_d = ctrl_serial_q ? '0 : speed_q;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            speed_q <= '0;
        end else if (ce) begin
            speed_q <= speed_d;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            speed_level <= '0;
        end else if (ce) begin
            speed_level <= level_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Serial speed frame: start bit low, then 16 bits LSB first
    logic [ssc_pkg::OUT_W:0] ser_shift_q;
    logic [4:0] ser_bits_q;
    logic [ssc_pkg::CNT_W-1:0] ser_tick_q;
    assign ser_busy = (ser_bits_q != 5'h0);
    wire bit_end = (ser_tick_q == ssc_pkg::SER_BIT_CYC - 6'h1);

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ser_shift_q <= '1;
            ser_bits_q <= '0;
            ser_tick_q <= '0;
        end else if (ce) begin
            if (!ser_busy) begin
                if (ctrl_serial_q) begin
                    ser_shift_q <= {speed_q, 1'b0};
                    ser_bits_q <= ssc_pkg::SER_FRAME_BITS;
                    ser_tick_q <= '0;
                end
            end else begin
                ser_tick_q <= bit_end ? '0 : ser_tick_q + 6'h1;
                if (bit_end) begin
                    ser_shift_q <= {1'b1, ser_shift_q[ssc_pkg::OUT_W:1]};
                    ser_bits_q <= ser_bits_q - 5'h1;
                end
            end
        end
    end

    // Line driver, idle high outside frames
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            speed_serial_data <= 1'b1;
            speed_serial_frame <= 1'b0;
        end else if (ce) begin
            speed_serial_frame <= ser_busy;
            speed_serial_data <= ser_busy ? ser_shift_q[0] : 1'b1;
        end
    end

    assign avs_waitrequest = waitreq_q;
    assign avs_readdata = rdata_q;

endmodule : ssc_spindle_scaler

// File: include/ssc_pkg.sv
package ssc_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Bus geometry
    localparam int ADDR_W = 6;
    localparam int DATA_W = 32;

    // Register byte offsets
    localparam logic [5:0] OFS_CTRL = 6'h00;
    localparam logic [5:0] OFS_SCMD = 6'h04;
    localparam logic [5:0] OFS_OVR_REG = 6'h08;
    localparam logic [5:0] OFS_STATUS = 6'h0c;
    localparam logic [5:0] OFS_SPEED = 6'h10;
    localparam logic [5:0] OFS_EFF_OVR = 6'h14;
    localparam logic [5:0] OFS_FULL_SCALE0 = 6'h20;
    localparam logic [5:0] OFS_MAX_SPEED0 = 6'h30;
    localparam logic [5:0] GEAR_STRIDE = 6'h04;

    // Field positions
    localparam int CTRL_SERIAL_BIT = 0;
    localparam int ST_HALT_BIT = 0;
    localparam int ST_METHOD_BIT = 1;
    localparam int ST_GEAR_LSB = 2;
    localparam int ST_BLOCKED_BIT = 4;
    localparam int ST_BUSY_BIT = 5;
    localparam int ST_SER_BUSY_BIT = 6;

    ////////////////////////////////////////////////////////////////////////////
    // Widths
    localparam int GEARS = 4;
    localparam int S_W = 16;
    localparam int PCT_W = 8;
    localparam int OUT_W = 16;
    localparam int NUM_W = 40;
    localparam int DEN_W = 23;
    localparam int CNT_W = 6;

    // Scaling constants
    localparam logic [OUT_W-1:0] FULL_SCALE_OUT = 16'hffff;
    localparam logic [6:0] PCT_DIVISOR = 7'h64;
    localparam logic [5:0] DIV_STEPS = 6'h28;

    // Code method ratios, 50 to 120 percent in 10 percent steps
    localparam logic [PCT_W-1:0] PCT_50 = 8'h32;
    localparam logic [PCT_W-1:0] PCT_60 = 8'h3c;
    localparam logic [PCT_W-1:0] PCT_70 = 8'h46;
    localparam logic [PCT_W-1:0] PCT_80 = 8'h50;
    localparam logic [PCT_W-1:0] PCT_90 = 8'h5a;
    localparam logic [PCT_W-1:0] PCT_100 = 8'h64;
    localparam logic [PCT_W-1:0] PCT_110 = 8'h6e;
    localparam logic [PCT_W-1:0] PCT_120 = 8'h78;

    // Reset values
    localparam logic [S_W-1:0] RST_SCMD = 16'h0000;
    localparam logic [PCT_W-1:0] RST_OVR_REG = 8'h64;
    localparam logic [S_W-1:0] RST_FULL_SCALE = 16'h0bb8;
    localparam logic [S_W-1:0] RST_MAX_SPEED = 16'h0bb8;

    ////////////////////////////////////////////////////////////////////////////
    // Serial link timing
    localparam int CLK_NS = 25;
    localparam int SER_BIT_NS = 1000;
    localparam int SER_BIT_CYC_I = (SER_BIT_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [CNT_W-1:0] SER_BIT_CYC = CNT_W'(SER_BIT_CYC_I);
    localparam logic [4:0] SER_FRAME_BITS = 5'h11;

    ////////////////////////////////////////////////////////////////////////////
    // Types
    typedef struct packed {
        logic halt;
        logic method;
        logic [1:0] gear;
        logic [2:0] code;
        logic tapping;
        logic threading;
    } ssc_pins_s;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_LOAD = 4'b0010,
        ST_DIV = 4'b0100,
        ST_DONE = 4'b1000
    } ssc_state_e;

endpackage : ssc_pkg

// File: tb/ssc_spindle_scaler_properties.sv
`timescale 1ns/1ps
module ssc_scaler_checker (
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [ssc_pkg::DATA_W-1:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic spindle_halt,
    input wire logic [ssc_pkg::OUT_W-1:0] speed_level,
    input wire logic speed_serial_data,
    input wire logic speed_serial_frame
);
    localparam int FRAME_CYC = ssc_pkg::SER_BIT_CYC_I * int'(ssc_pkg::SER_FRAME_BITS);
    logic [10:0] frame_cnt_q;
    // Frame length counter
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            frame_cnt_q <= '0;
        end else if (!speed_serial_frame) begin
            frame_cnt_q <= '0;
        end else if (ce) begin
            frame_cnt_q <= frame_cnt_q + 11'h001;
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    AST_HALT_ZERO: assert property ((spindle_halt && ce) [*5] |-> speed_level == '0)
        else $error("speed not zero while halted");
    AST_START_BIT: assert property ($rose(speed_serial_frame) |-> (!speed_serial_data) [*8])
        else $error("frame does not open with a low start bit");
    AST_FRAME_LEN: assert property ($fell(speed_serial_frame) |-> frame_cnt_q == 11'(FRAME_CYC))
        else $error("frame length wrong");
    AST_SER_IDLE: assert property (!speed_serial_frame |-> speed_serial_data)
        else $error("serial line not high outside frame");
    AST_SER_NO_LEVEL: assert property (speed_serial_frame |-> speed_level == '0)
        else $error("level output active during serial frame");
    AST_BIT_HOLD: assert property (speed_serial_frame && $changed(speed_serial_data) |=>
        $stable(speed_serial_data) [*8])
        else $error("serial bit too short");
    AST_WAIT_ANSWER: assert property (ce && (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("bus answer late");
    AST_WAIT_ONE: assert property (ce && !avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low too long");
    AST_RDATA_HOLD: assert property (!(ce && avs_read && avs_waitrequest) |=> $stable(avs_readdata))
        else $error("read data changed without a read");
    COV_FRAME: cover property ($fell(speed_serial_frame));
    COV_HALT: cover property (spindle_halt [*5]);
    COV_WRITE: cover property (avs_write && !avs_waitrequest);
endmodule : ssc_scaler_checker

bind ssc_spindle_scaler ssc_scaler_checker u_chk (.clk(clk), .rstn(rstn), .ce(ce), .avs_read(avs_read),
    .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .spindle_halt(spindle_halt), .speed_level(speed_level), .speed_serial_data(speed_serial_data),
    .speed_serial_frame(speed_serial_frame));

// File: tb/ssc_drive_model.sv
`timescale 1ns/1ps
module ssc_drive_model (
    input wire logic clk,
    input wire logic rstn,
    input wire logic speed_serial_data,
    input wire logic speed_serial_frame,
    output logic [15:0] rx_word,
    output logic [15:0] rx_frames
);
    localparam int BIT_CYC = ssc_pkg::SER_BIT_CYC_I;
    int cnt_q;
    logic [15:0] shift_q;
    logic mid_bit;
    // Sample in the middle of each bit, skip the start bit
    assign mid_bit = (cnt_q % BIT_CYC) == BIT_CYC / 2 && cnt_q >= BIT_CYC;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cnt_q <= 0;
            shift_q <= 16'h0;
            rx_word <= 16'h0;
            rx_frames <= 16'h0;
        end else if (speed_serial_frame) begin
            cnt_q <= cnt_q + 1;
            if (mid_bit) begin
                shift_q <= {speed_serial_data, shift_q[15:1]};
            end
        end else if (cnt_q != 0) begin
            cnt_q <= 0;
            rx_word <= shift_q;
            rx_frames <= rx_frames + 16'h1;
        end
    end
endmodule : ssc_drive_model

// File: tb/testbench.sv
`timescale 1ns/1ps
module testbench;
    logic clk;
    logic rstn;
    logic ce;
    logic [ssc_pkg::ADDR_W-1:0] avs_address;
    logic avs_read;
    logic avs_write;
    logic [ssc_pkg::DATA_W-1:0] avs_writedata;
    logic [ssc_pkg::DATA_W-1:0] avs_readdata;
    logic avs_waitrequest;
    ssc_pkg::ssc_pins_s pins;
    logic [15:0] speed_level;
    logic ser_data;
    logic ser_frame;
    logic [15:0] rx_word;
    logic [15:0] rx_frames;
    logic [15:0] fs_t [4];
    logic [15:0] mx_t [4];
    logic [31:0] rd;
    int err_count;
    int checks;

    ssc_spindle_scaler u_dut (.clk(clk), .rstn(rstn), .ce(ce), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .override_method_select(pins.method),
        .override_code_bit1(pins.code[0]), .override_code_bit2(pins.code[1]), .override_code_bit4(pins.code[2]),
        .gear_select_low(pins.gear[0]), .gear_select_high(pins.gear[1]), .spindle_halt(pins.halt),
        .tapping_mode(pins.tapping), .thread_cutting_mode(pins.threading), .speed_level(speed_level),
        .speed_serial_data(ser_data), .speed_serial_frame(ser_frame));
    ssc_drive_model u_drive (.clk(clk), .rstn(rstn), .speed_serial_data(ser_data),
        .speed_serial_frame(ser_frame), .rx_word(rx_word), .rx_frames(rx_frames));

    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [7:0] code_pct(input logic [2:0] c);
        case (c)
            3'h7: return 8'h32;
            3'h3: return 8'h3c;
            3'h2: return 8'h46;
            3'h6: return 8'h50;
            3'h4: return 8'h5a;
            3'h0: return 8'h64;
            3'h1: return 8'h6e;
            default: return 8'h78;
        endcase
    endfunction : code_pct

    function automatic logic [15:0] exp_speed(input logic [15:0] s, mx, fs, input logic [7:0] p);
        logic [63:0] q;
        q = (s > mx) ? {48'h0, mx} : {48'h0, s};
        q = q * p * 64'hffff / ({48'h0, fs} * 64'h64);
        return (q > 64'hffff) ? 16'hffff : q[15:0];
    endfunction : exp_speed

    task automatic summarize;
        $display("checks=%0d err_count=%0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : summarize

    task automatic cmp_reg(input logic [31:0] got, exp);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp_reg

    task automatic cmp_speed(input logic [15:0] got, exp);
        cmp_reg({16'h0, got}, {16'h0, exp});
    endtask : cmp_speed

    // Avalon transfer, held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
        int n;
        n = 0;
        avs_address <= a;
        avs_writedata <= d;
        avs_read <= !wr;
        avs_write <= wr;
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 64);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (n >= 64) begin
            err_count++;
            summarize();
        end
        @(posedge clk);
    endtask : bus

    task automatic rdc(input logic [5:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        cmp_reg(rd, exp);
    endtask : rdc

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        int i;
        int g;
        logic [7:0] v;
        logic [2:0] c;
        logic [15:0] s;
        logic [15:0] ex;
        err_count = 0;
        checks = 0;
        rstn = 1'b0;
        ce = 1'b1;
        avs_address = '0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = '0;
        pins = '0;
        void'($urandom(32'h46e0));
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        rdc(ssc_pkg::OFS_OVR_REG, 32'h64);
        rdc(ssc_pkg::OFS_FULL_SCALE0, 32'hbb8);
        rdc(ssc_pkg::OFS_MAX_SPEED0 + 6'h0c, 32'hbb8);
        bus(1'b1, ssc_pkg::OFS_EFF_OVR, 32'h11);
        bus(1'b1, 6'h18, 32'hff);
        rdc(ssc_pkg::OFS_EFF_OVR, 32'h64);
        rdc(6'h18, 32'h0);
        for (i = 0; i < 8; i++) begin
            pins.code <= 3'(i);
            repeat (8) @(posedge clk);
            rdc(ssc_pkg::OFS_EFF_OVR, {24'h0, code_pct(3'(i))});
        end
        v = 8'($urandom());
        bus(1'b1, ssc_pkg::OFS_OVR_REG, {24'h0, v});
        pins.method <= 1'b1;
        pins.code <= 3'h4;
        repeat (8) @(posedge clk);
        rdc(ssc_pkg::OFS_EFF_OVR, {24'h0, v});
        pins.method <= 1'b0;
        for (i = 0; i < 3; i++) begin
            pins.code <= 3'h0;
            repeat (8) @(posedge clk);
            pins.halt <= (i == 0);
            pins.tapping <= (i == 1);
            pins.threading <= (i == 2);
            repeat (8) @(posedge clk);
            pins.code <= 3'h7;
            repeat (8) @(posedge clk);
            rdc(ssc_pkg::OFS_EFF_OVR, 32'h64);
            pins.halt <= 1'b0;
            pins.tapping <= 1'b0;
            pins.threading <= 1'b0;
            repeat (8) @(posedge clk);
            rdc(ssc_pkg::OFS_EFF_OVR, 32'h32);
        end
        for (i = 0; i < 12; i++) begin
            for (g = 0; g < 4; g++) begin
                fs_t[g] = (i < 2) ? 16'h7d0 : 16'($urandom_range(65535, 256));
                mx_t[g] = (i == 0) ? 16'hffff : (i == 1) ? 16'h3e8 : 16'($urandom());
                bus(1'b1, ssc_pkg::OFS_FULL_SCALE0 + 6'(4 * g), {16'h0, fs_t[g]});
                bus(1'b1, ssc_pkg::OFS_MAX_SPEED0 + 6'(4 * g), {16'h0, mx_t[g]});
            end
            s = (i < 2) ? 16'h514 : 16'($urandom());
            c = (i < 2) ? 3'h0 : 3'($urandom());
            bus(1'b1, ssc_pkg::OFS_SCMD, {16'h0, s});
            pins.gear <= (i < 2) ? 2'h1 : 2'($urandom());
            pins.code <= c;
            repeat (150) @(posedge clk);
            ex = exp_speed(s, mx_t[pins.gear], fs_t[pins.gear], code_pct(c));
            cmp_speed(speed_level, ex);
            if (i == 1) begin
                ce <= 1'b0;
                pins.halt <= 1'b1;
                repeat (10) @(posedge clk);
                cmp_speed(speed_level, ex);
                pins.halt <= 1'b0;
                ce <= 1'b1;
                repeat (4) @(posedge clk);
            end
            if (i == 0) begin
                pins.halt <= 1'b1;
                repeat (6) @(posedge clk);
                cmp_speed(speed_level, 16'h0);
                pins.halt <= 1'b0;
                repeat (150) @(posedge clk);
                cmp_speed(speed_level, ex);
            end
        end
        bus(1'b1, ssc_pkg::OFS_CTRL, 32'h1);
        g = int'(rx_frames) + 2;
        for (i = 0; i < 4000 && int'(rx_frames) < g; i++) begin
            @(posedge clk);
        end
        if (int'(rx_frames) < g) begin
            err_count++;
            summarize();
        end
        cmp_speed(rx_frames, 16'(g));
        cmp_speed(rx_word, ex);
        cmp_speed(speed_level, 16'h0);
        summarize();
    end
endmodule : testbench
